// ===== rtl/rss_pkg.sv
// constants for the receive-side sync, clock and alarm output block
package rss_pkg;
  // operating modes, as held in the control register mode field
  typedef enum logic [1:0] {RSS_T1, RSS_E1, RSS_CC, RSS_M6312} rss_mode_e;

  // register offsets (byte addresses) on the plain register port
  localparam logic [3:0] RSS_OFS_CTRL   = 4'h0;
  localparam logic [3:0] RSS_OFS_STATUS = 4'h4;
  localparam logic [31:0] RSS_CTRL_RESET = 32'h0000_0000;

  // control field positions
  localparam int RSS_CF_MODE = 0;  // two bits
  localparam int RSS_CF_SBS  = 2;  // sync boundary select
  localparam int RSS_CF_DWS  = 3;  // double wide sync enable
  localparam int RSS_CF_TCLS = 4;  // tx clock loss indicator select
  localparam int RSS_CF_PAY  = 5;  // payload (gapped clock) enable
  localparam int RSS_CF_A400 = 6;  // composite 400 Hz output enable
  // status field positions
  localparam int RSS_SF_LOS  = 0;
  localparam int RSS_SF_AIS  = 1;
  localparam int RSS_SF_LOF  = 2;
  localparam int RSS_SF_TCL  = 3;

  // frame geometry in recovered-clock periods
  localparam int RSS_T1_FRAME_BITS = 193;
  localparam int RSS_E1_FRAME_BITS = 256;
  localparam int RSS_E1_TS16_FIRST = 128;
  localparam int RSS_SLOT_BITS     = 8;
  localparam int RSS_T1_SF_FRAMES  = 12;
  localparam int RSS_T1_SIG_A      = 5;  // sixth frame, zero based
  localparam int RSS_T1_SIG_B      = 11; // twelfth frame

  // loss of signal thresholds
  localparam int RSS_LOS_T1_ZEROS = 192;
  localparam int RSS_LOS_E1_ZEROS = 255;
  localparam int RSS_CC_KHZ       = 64;
  localparam int RSS_M6312_KHZ    = 6312;
  localparam int RSS_LOS_CC_NS    = 120000;
  localparam int RSS_LOS_6312_NS  = 60000;
  // least times round up to whole link periods
  localparam int RSS_LOS_CC_ZEROS = (RSS_LOS_CC_NS * RSS_CC_KHZ + 999999) / 1000000;
  localparam int RSS_LOS_6312_ZEROS = (RSS_LOS_6312_NS * RSS_M6312_KHZ + 999999) / 1000000;

  // composite clock component periods in 64 kHz periods
  localparam int RSS_CC_8K_PER  = 8;
  localparam int RSS_CC_400_PER = 160;

  // transmit clock loss: periods of the scaled master clock
  localparam int RSS_TX_CLOCK_LOSS_PERIODS = 15;
  // ones run that declares all-ones alarm (one T1 superframe)
  localparam int RSS_AIS_ONES = 2316;
endpackage : rss_pkg

// ===== rtl/rss_rx_outputs.sv
// receive-side clock, sync, serial data and alarm pin logic
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rss_rx_outputs (
  // system clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // register port, system domain
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // recovered clock and line-side inputs, link domain
  input  wire logic        clk_link,
  input  wire logic        rx_data_in,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_mframe_start,
  input  wire logic        rx_frame_search,
  input  wire logic        cc_8k_mark,
  input  wire logic        cc_400_mark,
  // asynchronous pins
  input  wire logic        level_low_in,
  input  wire logic        tx_clock_in,
  // receive pins, with enables for all but the clock and signal loss pins
  output logic             rx_clock_out,
  output logic             rx_frame_sync_out,
  output logic             rx_frame_sync_oe,
  output logic             composite_out_a,
  output logic             composite_out_a_oe,
  output logic             rx_serial_data_out,
  output logic             rx_serial_data_oe,
  output logic             rx_frame_loss_cc_error,
  output logic             rx_frame_loss_cc_error_oe,
  output logic             rx_signal_loss,
  output logic             rx_alarm_indication,
  output logic             rx_alarm_indication_oe
);
  import rss_pkg::*;

  logic [31:0] ctrl;          // control register
  logic [3:0]  tx_clock_loss_cnt;      // idle master-clock periods on tx clock
  logic [2:0]  tx_clock_in_s;        // tx clock sync pair plus history
  logic        tx_clock_loss; // sys domain loss flag
  logic [1:0]  st_s0, st_s1;  // status pairs into sys (los, ais)
  logic        lof_s0, lof_s1;
  logic [1:0]  rst_lk;        // link reset release
  logic        rst_lk_b;
  logic [6:0]  cf_s0, cf_s1;  // control pair into link domain
  logic        tcl_s0, tcl_s1;
  logic        lvl_s0, lvl_s1;
  rss_mode_e   mode;
  logic        t1, e1, cc, m6312;
  logic [7:0]  bit_pos;       // bit position in frame
  logic [7:0]  next_bit_pos;
  logic [3:0]  frame_idx;     // frame within T1 superframe
  logic [3:0]  next_frame_idx;
  logic        gap_next;      // coming period falls in a payload gap
  logic        gate_neg;      // inverse of that, held over the high phase
  logic        dw_pend;       // second period of a wide pulse due
  logic [8:0]  zero_run;      // consecutive received zeros
  logic [11:0] ones_run;      // consecutive received ones
  logic [2:0]  ph8;           // 8 kHz phase
  logic [7:0]  ph400;         // 400 Hz phase
  logic        err8, err400;  // component error flags

  // link-domain reset: asserts at once, releases on the link clock
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) rst_lk <= 2'b00;
    else        rst_lk <= {rst_lk[0], 1'b1};
  end
  assign rst_lk_b = rst_lk[1];

  // control register write; the framer config is quasi-static
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) ctrl <= RSS_CTRL_RESET;
    else if (reg_wr && reg_addr == RSS_OFS_CTRL) ctrl <= reg_wdata;
  end

  // read data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 32'h0000_0000;
    else if (reg_rd && reg_addr == RSS_OFS_CTRL)
      reg_rdata <= {25'h0, ctrl[6:0]};
    else if (reg_rd && reg_addr == RSS_OFS_STATUS)
      reg_rdata <= {28'h0, tx_clock_loss, lof_s1, st_s1[1], st_s1[0]};
    else reg_rdata <= 32'h0000_0000;
  end

  // tx clock sampled twice before the edge detector looks at it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) tx_clock_in_s <= 3'h0;
    else        tx_clock_in_s <= {tx_clock_in_s[1:0], tx_clock_in};
  end

  // count master periods without a tx clock edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_clock_loss_cnt      <= 4'h0;
      tx_clock_loss <= 1'b0;
    end else if (tx_clock_in_s[2] != tx_clock_in_s[1]) begin
      tx_clock_loss_cnt      <= 4'h0; // edge seen: loss clears at once
      tx_clock_loss <= 1'b0;
    end else if (tx_clock_loss_cnt != 4'(RSS_TX_CLOCK_LOSS_PERIODS)) begin
      tx_clock_loss_cnt      <= tx_clock_loss_cnt + 4'h1;
    end else begin
      tx_clock_loss <= 1'b1;
    end
  end

  // link status levels back into the system domain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_s0 <= 2'h0;
      st_s1 <= 2'h0;
      lof_s0 <= 1'b0;
      lof_s1 <= 1'b0;
    end else begin
      st_s0 <= {rx_alarm_indication, rx_signal_loss};
      st_s1 <= st_s0;
      lof_s0 <= rx_frame_loss_cc_error;
      lof_s1 <= lof_s0;
    end
  end

  // control bits, tx clock loss and analog level into link domain
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      cf_s0 <= 7'h0;
      cf_s1 <= 7'h0;
      tcl_s0 <= 1'b0;
      tcl_s1 <= 1'b0;
      lvl_s0 <= 1'b0;
      lvl_s1 <= 1'b0;
    end else begin
      cf_s0 <= ctrl[6:0];
      cf_s1 <= cf_s0;
      tcl_s0 <= tx_clock_loss;
      tcl_s1 <= tcl_s0;
      lvl_s0 <= level_low_in;
      lvl_s1 <= lvl_s0;
    end
  end

  assign mode  = rss_mode_e'(cf_s1[RSS_CF_MODE +: 2]);
  assign t1    = (mode == RSS_T1);
  assign e1    = (mode == RSS_E1);
  assign cc    = (mode == RSS_CC);
  assign m6312 = (mode == RSS_M6312);

  // frame and superframe position from the framer strobes
  always_comb begin
    next_bit_pos = bit_pos + 8'h1;
    if (t1 && bit_pos == 8'(RSS_T1_FRAME_BITS - 1)) next_bit_pos = 8'h0;
    if (rx_frame_start) next_bit_pos = 8'h0;
    next_frame_idx = frame_idx;
    if (rx_mframe_start) next_frame_idx = 4'h0;
    else if (rx_frame_start)
      next_frame_idx = (frame_idx == 4'(RSS_T1_SF_FRAMES - 1)) ? 4'h0 : frame_idx + 4'h1;
  end

  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      bit_pos   <= 8'h0;
      frame_idx <= 4'h0;
    end else begin
      bit_pos   <= next_bit_pos;
      frame_idx <= next_frame_idx;
    end
  end

  // gap decision one period ahead, so the gate is settled
  // before the high phase it masks
  // next_bit_pos already folds in a pending frame start, so at the
  // falling edge it names the position the coming rise opens;
  // the gap therefore tests that position directly
  // limitation: a framer that slips mid-frame shifts the gaps
  // until its next frame start re-aligns the position
  always_comb begin
    gap_next = 1'b0;
    if (cf_s1[RSS_CF_PAY] && t1)
      gap_next = (next_bit_pos == 8'h0);
    // E1: slot 0 and slot 16, eight periods each
    if (cf_s1[RSS_CF_PAY] && e1)
      gap_next = (next_bit_pos < 8'(RSS_SLOT_BITS)) ||
                 (next_bit_pos >= 8'(RSS_E1_TS16_FIRST) &&
                  next_bit_pos < 8'(RSS_E1_TS16_FIRST + RSS_SLOT_BITS));
  end

  // gate moves on the falling edge: no runt pulses on the pin
  always_ff @(negedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) gate_neg <= 1'b1;
    else           gate_neg <= !gap_next;
  end
  // the only output not taken straight from a flip-flop:
  // the recovered clock itself, passed through a glitch-free gate
  assign rx_clock_out = clk_link & gate_neg;

  // sync / 8 kHz pin and its enable
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      rx_frame_sync_out <= 1'b0;
      rx_frame_sync_oe  <= 1'b0;
      dw_pend           <= 1'b0;
    end else begin
      rx_frame_sync_oe <= !m6312;
      dw_pend <= 1'b0;
      if (cc)
        rx_frame_sync_out <= (ph8 < 3'(RSS_CC_8K_PER / 2));
      else if (m6312)
        rx_frame_sync_out <= 1'b0;
      else if (cf_s1[RSS_CF_SBS])
        rx_frame_sync_out <= rx_mframe_start;
      else begin
        rx_frame_sync_out <= rx_frame_start | dw_pend;
        dw_pend <= rx_frame_start && t1 && cf_s1[RSS_CF_DWS] &&
                   (next_frame_idx == 4'(RSS_T1_SIG_A) ||
                    next_frame_idx == 4'(RSS_T1_SIG_B));
      end
    end
  end

  // composite clock phases, resynchronised by the decoder marks
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      ph8    <= 3'h0;
      ph400  <= 8'h0;
      err8   <= 1'b0;
      err400 <= 1'b0;
    end else begin
      ph8   <= cc_8k_mark ? 3'h1 : ph8 + 3'h1;
      ph400 <= (cc_400_mark || ph400 == 8'(RSS_CC_400_PER - 1)) ? 8'h0 + {7'h0, cc_400_mark}
               : ph400 + 8'h1;
      // a mark off its slot, or a slot with no mark, is an error;
      // an on-time mark clears it
      if (cc && (cc_8k_mark != (ph8 == 3'h0))) err8 <= 1'b1;
      else if (cc_8k_mark) err8 <= 1'b0;
      if (cc && (cc_400_mark != (ph400 == 8'h0))) err400 <= 1'b1;
      else if (cc_400_mark) err400 <= 1'b0;
    end
  end

  // 400 Hz pin, driven in composite mode only when enabled
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      composite_out_a    <= 1'b0;
      composite_out_a_oe <= 1'b0;
    end else begin
      composite_out_a_oe <= cc && cf_s1[RSS_CF_A400];
      composite_out_a    <= (ph400 < 8'(RSS_CC_400_PER / 2));
    end
  end

  // NRZ data retimed on the recovered clock rise
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      rx_serial_data_out <= 1'b0;
      rx_serial_data_oe  <= 1'b0;
    end else begin
      rx_serial_data_out <= rx_data_in;
      rx_serial_data_oe  <= t1 | e1;
    end
  end

  // frame loss / tx clock loss / composite error pin
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      rx_frame_loss_cc_error    <= 1'b0;
      rx_frame_loss_cc_error_oe <= 1'b0;
    end else begin
      rx_frame_loss_cc_error_oe <= !m6312;
      if (cc) rx_frame_loss_cc_error <= err8 | err400;
      else if (cf_s1[RSS_CF_TCLS]) rx_frame_loss_cc_error <= tcl_s1;
      else rx_frame_loss_cc_error <= rx_frame_search & !m6312;
    end
  end

  // zero and ones runs, saturating
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      zero_run <= 9'h0;
      ones_run <= 12'h0;
    end else begin
      zero_run <= rx_data_in ? 9'h0 : (zero_run == 9'h1ff ? zero_run : zero_run + 9'h1);
      ones_run <= !rx_data_in ? 12'h0 : (ones_run == 12'hfff ? ones_run : ones_run + 12'h1);
    end
  end

  // loss of signal; a one on the line clears it (and a good level)
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) rx_signal_loss <= 1'b0;
    else begin
      case (mode)
        RSS_T1:  rx_signal_loss <= zero_run >= 9'(RSS_LOS_T1_ZEROS);
        RSS_E1:  rx_signal_loss <= zero_run >= 9'(RSS_LOS_E1_ZEROS);
        RSS_CC:  rx_signal_loss <= lvl_s1 ||
                   zero_run >= 9'(RSS_LOS_CC_ZEROS);
        default: rx_signal_loss <= zero_run >= 9'(RSS_LOS_6312_ZEROS);
      endcase
    end
  end

  // alarm indication: long all-ones run, cleared by any zero
  always_ff @(posedge clk_link or negedge rst_lk_b) begin
    if (!rst_lk_b) begin
      rx_alarm_indication    <= 1'b0;
      rx_alarm_indication_oe <= 1'b0;
    end else begin
      rx_alarm_indication_oe <= t1 | e1;
      rx_alarm_indication <= (t1 | e1) && ones_run >= 12'(RSS_AIS_ONES);
    end
  end

  // checks on the link side, plus tx clock loss on the system side
  chk_los_t1: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    (t1 && $past(t1) && zero_run == 9'(RSS_LOS_T1_ZEROS)) |=> rx_signal_loss)
    else $error("t1 loss of signal late");
  chk_los_e1: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    (e1 && zero_run == 9'(RSS_LOS_E1_ZEROS - 1)) |=> !rx_signal_loss)
    else $error("e1 loss of signal early");
  chk_los_clear: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    (!cc && rx_data_in) ##1 !rx_data_in |=> !rx_signal_loss)
    else $error("loss of signal held after a one");
  chk_sync_single: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    (!cc && !cf_s1[RSS_CF_DWS] && !rx_frame_start) ##1 (!rx_frame_start && !cc)
    |-> ##1 !rx_frame_sync_out)
    else $error("sync pulse wider than one period");
  chk_sync_wide: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    dw_pend |=> rx_frame_sync_out)
    else $error("double wide pulse lost second period");
  chk_hiz_6312: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    m6312 |=> !rx_frame_sync_oe && !composite_out_a_oe && !rx_alarm_indication_oe)
    else $error("pin driven in 6312 mode");
  chk_ser_follow: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    rst_lk_b |=> rx_serial_data_out == $past(rx_data_in))
    else $error("serial data not retimed");
  chk_lof_search: assert property (@(posedge clk_link) disable iff (!rst_lk_b)
    (t1 && !cf_s1[RSS_CF_TCLS] && rx_frame_search) |=> rx_frame_loss_cc_error)
    else $error("frame loss not shown");
  chk_gap_t1: assert property (@(negedge clk_link) disable iff (!rst_lk_b)
    (cf_s1[RSS_CF_PAY] && t1 && gap_next) |=> !gate_neg)
    else $error("gapped clock not gapped");
  chk_tx_clock_loss_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tx_clock_loss_cnt == 4'(RSS_TX_CLOCK_LOSS_PERIODS) && tx_clock_in_s[2] == tx_clock_in_s[1]) |=> tx_clock_loss)
    else $error("tx clock loss missed");
  cov_los: cover property (@(posedge clk_link) disable iff (!rst_lk_b) $rose(rx_signal_loss));
  cov_wide: cover property (@(posedge clk_link) disable iff (!rst_lk_b) dw_pend);
  cov_ccerr: cover property (@(posedge clk_link) disable iff (!rst_lk_b)
    cc && rx_frame_loss_cc_error);
  cov_tx_clock_loss: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(tx_clock_loss));
endmodule : rss_rx_outputs

// ===== test/rss_line_model.sv
// line-side model: recovered clock, line data, framer pulses and composite marks
`timescale 1ns/1ps
module rss_line_model (
  // controls from the bench
  input  wire logic       data_src,
  input  wire logic       search_req,
  input  wire logic [8:0] frame_len,
  // line side toward the block
  output logic            clk_link,
  output logic            rx_data_in,
  output logic            rx_frame_start,
  output logic            rx_mframe_start,
  output logic            rx_frame_search,
  output logic            cc_8k_mark,
  output logic            cc_400_mark
);
  logic [8:0] bit_cnt = 9'h000;  // bit within frame
  logic [3:0] frm_cnt = 4'h0;    // frame within multiframe
  logic [7:0] cc_cnt  = 8'h00;   // 64 kHz period within one 400 Hz cycle
  // recovered clock runs free; odd offset keeps it unrelated to clk_sys
  initial begin
    rx_data_in      = 1'b0;
    rx_frame_start  = 1'b0;
    rx_mframe_start = 1'b0;
    rx_frame_search = 1'b0;
    cc_8k_mark      = 1'b0;
    cc_400_mark     = 1'b0;
    clk_link        = 1'b0;
    #3.7;
    forever #62.5 clk_link = ~clk_link;
  end
  // frame pulse on bit 0, multiframe every 12 frames, marks every 8 and 160
  always @(posedge clk_link) begin
    rx_data_in      <= data_src;
    rx_frame_search <= search_req;
    bit_cnt         <= (bit_cnt >= frame_len - 9'h001) ? 9'h000 : bit_cnt + 9'h001;
    rx_frame_start  <= (bit_cnt >= frame_len - 9'h001);
    rx_mframe_start <= (bit_cnt >= frame_len - 9'h001) && (frm_cnt == 4'hb);
    if (bit_cnt >= frame_len - 9'h001) begin
      frm_cnt <= (frm_cnt == 4'hb) ? 4'h0 : frm_cnt + 4'h1;
    end
    cc_cnt      <= (cc_cnt == 8'h9f) ? 8'h00 : cc_cnt + 8'h01;
    cc_8k_mark  <= (cc_cnt[2:0] == 3'h7);
    cc_400_mark <= (cc_cnt == 8'h9f);
  end
endmodule : rss_line_model

// ===== test/rss_rx_outputs_tb.sv
// self-checking bench for the receive-side sync, clock and alarm pins
`timescale 1ns/1ps
module rss_rx_outputs_tb;
  import rss_pkg::*;
  // system side
  logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        level_low_in = 1'b0, tx_clock_in = 1'b0, txc_run = 1'b1;
  // line side and pins
  logic        clk_link, rx_data_in, rx_frame_start, rx_mframe_start, rx_frame_search;
  logic        cc_8k_mark, cc_400_mark, data_src = 1'b0, search_req = 1'b0;
  logic [8:0]  frame_len = 9'h0c1;
  logic        rx_clock_out, rx_frame_sync_out, rx_frame_sync_oe, composite_out_a;
  logic        composite_out_a_oe, rx_serial_data_out, rx_serial_data_oe, rx_signal_loss;
  logic        rx_frame_loss_cc_error, rx_frame_loss_cc_error_oe;
  logic        rx_alarm_indication, rx_alarm_indication_oe;
  // model state: run lengths of zeros and ones seen by the block
  int          num_errors = 0, n_tests = 0, zc = 0, oc = 0, thr, cnt, c4, ce;
  logic [31:0] ctrl = 32'h0, rdv, rnd = 32'h0000_be7b;
  logic [1:0]  dmode = 2'h0;  // 0 random, 1 zeros, 2 ones
  logic        samp = 1'b0, srch = 1'b0, chk_on = 1'b0;

  always #5 clk_sys = ~clk_sys;
  // transmit clock toggles each cycle until a scenario stops it
  always @(posedge clk_sys) if (txc_run) tx_clock_in <= ~tx_clock_in;

  rss_line_model line (.data_src, .search_req, .frame_len, .clk_link, .rx_data_in,
    .rx_frame_start, .rx_mframe_start, .rx_frame_search, .cc_8k_mark, .cc_400_mark);
  rss_rx_outputs DUT (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .clk_link, .rx_data_in, .rx_frame_start, .rx_mframe_start,
    .rx_frame_search, .cc_8k_mark, .cc_400_mark, .level_low_in, .tx_clock_in,
    .rx_clock_out, .rx_frame_sync_out, .rx_frame_sync_oe, .composite_out_a,
    .composite_out_a_oe, .rx_serial_data_out, .rx_serial_data_oe,
    .rx_frame_loss_cc_error, .rx_frame_loss_cc_error_oe, .rx_signal_loss,
    .rx_alarm_indication, .rx_alarm_indication_oe);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // register port master: one-cycle strobes, read data in the next cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // recovered clock pulses seen over n link periods
  task automatic clk_cnt(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk_link);
      #1;
      if (rx_clock_out === 1'b1) k++;
    end
  endtask : clk_cnt

  task automatic lwait(input int n);
    repeat (n) @(posedge clk_link);
  endtask : lwait

  // ones sweep while the mode crosses keeps model and block run counts equal
  task automatic set_mode(input logic [31:0] c, input logic [1:0] dm);
    chk_on = 1'b0;
    dmode  = 2'h2;
    ctrl   = c;
    wr(RSS_OFS_CTRL, c);
    lwait(8);
    dmode  = dm;
    chk_on = 1'b1;
  endtask : set_mode

  // line data source and run-length model, sampled where the block samples
  always @(posedge clk_link) begin
    rnd = xs(rnd);
    data_src <= (dmode == 2'h0) ? rnd[0] : dmode[1];
    samp = rx_data_in;
    srch = rx_frame_search;
    if (rx_data_in) begin
      oc++;
      zc = 0;
    end else begin
      zc++;
      oc = 0;
    end
  end

  // model compared with the pins at every link period; margins cover latency
  always @(negedge clk_link) if (chk_on) begin
    thr = (ctrl[1:0] == 2'h0) ? RSS_LOS_T1_ZEROS : (ctrl[1:0] == 2'h1) ? RSS_LOS_E1_ZEROS :
          (ctrl[1:0] == 2'h2) ? RSS_LOS_CC_ZEROS : RSS_LOS_6312_ZEROS;
    if (zc >= thr + 2) check(rx_signal_loss, 1);
    if (oc >= 2 || (zc >= 2 && zc < thr)) check(rx_signal_loss, 0);
    if (!ctrl[1]) begin
      check(rx_serial_data_out, samp);
      if (!ctrl[4]) check(rx_frame_loss_cc_error, srch);
      if (oc >= RSS_AIS_ONES + 2) check(rx_alarm_indication, 1);
      if (zc >= 2 || (oc >= 2 && oc < RSS_AIS_ONES)) check(rx_alarm_indication, 0);
    end
  end

  // hang guard
  initial begin
    #1300000;
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    repeat (3) @(posedge clk_link);
    @(posedge clk_sys) rst_b <= 1'b1;
    rd(RSS_OFS_CTRL, rdv);
    check(rdv, RSS_CTRL_RESET);
    wr(RSS_OFS_CTRL, 32'hffff_ffa5);
    wr(RSS_OFS_STATUS, 32'hffff_ffff);
    wr(4'hc, 32'h0000_0000);
    rd(RSS_OFS_CTRL, rdv);
    check(rdv, 32'h0000_0025);
    rd(4'h8, rdv);
    check(rdv, 32'h0000_0000);
    $display("register test done");
    // every mode with the 400 Hz enable off and on
    for (int i = 0; i < 8; i++) begin
      set_mode({25'h0, i[2], 4'h0, i[1:0]}, 2'h0);
      check({rx_frame_sync_oe, composite_out_a_oe, rx_serial_data_oe, rx_frame_loss_cc_error_oe,
             rx_alarm_indication_oe}, {i[1:0] != 2'h3, i == 6, !i[1], i[1:0] != 2'h3,
             !i[1]});
    end
    $display("output enable test done");
    set_mode(32'h0000_0020, 2'h1);
    lwait(200);
    rd(RSS_OFS_STATUS, rdv);
    check(rdv[RSS_SF_LOS], 1);
    clk_cnt(RSS_T1_FRAME_BITS, cnt);
    check(cnt, RSS_T1_FRAME_BITS - 1);
    dmode = 2'h0;
    lwait(30);
    search_req <= 1'b1;
    lwait(20);
    search_req <= 1'b0;
    lwait(20);
    $display("T1 loss and frame search test done");
    set_mode(32'h0000_0010, 2'h0);
    check(rx_frame_loss_cc_error, 0);
    txc_run = 1'b0;
    cnt = 0;
    while (rx_frame_loss_cc_error !== 1'b1 && cnt < 12) begin
      @(posedge clk_link);
      cnt++;
    end
    check(cnt >= 2 && cnt <= 8, 1);
    rd(RSS_OFS_STATUS, rdv);
    check(rdv[RSS_SF_TCL], 1);
    txc_run = 1'b1;
    lwait(6);
    check(rx_frame_loss_cc_error, 0);
    $display("tx clock loss test done");
    // sync pattern repeats every superframe, so any 12-frame window counts alike
    set_mode(32'h0000_0008, 2'h2);
    for (int k = 0; k < 2400 && rx_mframe_start !== 1'b1; k++) @(posedge clk_link);
    cnt = 0;
    repeat (12 * RSS_T1_FRAME_BITS) begin
      @(negedge clk_link);
      if (rx_frame_sync_out === 1'b1) cnt++;
    end
    check(cnt, 14);
    lwait(20);
    check(rx_alarm_indication, 1);
    set_mode(32'h0000_0004, 2'h0);
    cnt = 0;
    repeat (12 * RSS_T1_FRAME_BITS) begin
      @(negedge clk_link);
      if (rx_frame_sync_out === 1'b1) cnt++;
    end
    check(cnt, 1);
    $display("sync pulse test done");
    frame_len <= 9'h100;
    set_mode(32'h0000_0021, 2'h1);
    lwait(270);
    rd(RSS_OFS_STATUS, rdv);
    check(rdv[RSS_SF_LOS], 1);
    clk_cnt(RSS_E1_FRAME_BITS, cnt);
    check(cnt, RSS_E1_FRAME_BITS - 2 * RSS_SLOT_BITS);
    dmode = 2'h0;
    lwait(30);
    $display("E1 loss test done");
    set_mode(32'h0000_0042, 2'h0);
    lwait(200);
    cnt = 0;
    c4 = 0;
    ce = 0;
    repeat (160) begin
      @(negedge clk_link);
      if (rx_frame_sync_out === 1'b1) cnt++;
      if (composite_out_a === 1'b1) c4++;
      if (rx_frame_loss_cc_error !== 1'b0) ce++;
    end
    check(cnt, 80);
    check(c4, 80);
    check(ce, 0);
    clk_cnt(160, cnt);
    check(cnt, 160);
    dmode = 2'h1;
    lwait(20);
    chk_on = 1'b0;
    dmode = 2'h2;
    lwait(4);
    @(posedge clk_sys) level_low_in <= 1'b1;
    lwait(6);
    check(rx_signal_loss, 1);
    @(posedge clk_sys) level_low_in <= 1'b0;
    lwait(6);
    check(rx_signal_loss, 0);
    $display("composite clock test done");
    end_sim();
  end
endmodule : rss_rx_outputs_tb
